/* File: hw/rasp_pipeline.sv */
// reading average / relative offset / m*x+b pipeline with per-function settings
// assumes readings and configuration writes are synchronous to CLOCK
`default_nettype none
module rasp_pipeline
    import rasp_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH
) (
    input  wire logic                CLOCK,
    input  wire logic                RST_B,
    input  wire logic [1:0]          OP_MODE,
    input  wire logic [1:0]          FUNC_SEL,
    input  wire logic                AUTOZERO_EN,
    input  wire logic                IN_VALID,
    input  wire logic [DATA_W-1:0]   IN_DATA,
    input  wire logic                IN_IS_CURRENT,
    input  wire logic [DATA_W-1:0]   IN_RANGE_FS,
    input  wire logic                FILT_CLR,
    input  wire logic                BUF_SRC_POST,
    input  wire logic                CFG_WE,
    input  wire logic [1:0]          CFG_FUNC,
    input  wire logic [3:0]          CFG_SEL,
    input  wire logic [31:0]         CFG_DATA,
    output logic                     CFG_ERR,
    output logic                     REF_CONV_EN,
    output logic                     OUT_VALID,
    output logic [DATA_W-1:0]        OUT_DATA,
    output logic [DATA_W-1:0]        BUF_DATA,
    output logic [2:0]               OUT_DIGITS,
    output logic [7:0]               OUT_UNIT,
    output logic                     POSTPROC_ACTIVE_INDICATOR
);
    // per-function settings
    logic [2:0]        digits_reg  [0:3];
    logic              avg_en_reg  [0:3];
    logic [CNT_W-1:0]  count_reg   [0:3];
    logic [2:0]        window_reg  [0:3];
    logic              math_en_reg [0:3];
    logic [31:0]       gain_reg    [0:3];
    logic [31:0]       moff_reg    [0:3];
    logic [7:0]        unit_reg    [0:3];
    logic              rel_en_reg  [0:3];
    logic [31:0]       rel_val_reg [0:3];
    logic              cfg_err_reg;
    logic              cfg_batt;
    logic              supply;
    logic              curr_path;

    assign cfg_batt  = (OP_MODE != MODE_SUPPLY);
    assign supply    = (OP_MODE == MODE_SUPPLY);
    assign curr_path = (FUNC_SEL != FUNC_CONC) || IN_IS_CURRENT;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_err_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                digits_reg[i]  <= DIGITS_6;
                avg_en_reg[i]  <= 1'b0;
                count_reg[i]   <= CNT_RESET;
                window_reg[i]  <= WIN_0P01;
                math_en_reg[i] <= 1'b0;
                gain_reg[i]    <= GAIN_ONE;
                moff_reg[i]    <= 32'h0;
                unit_reg[i]    <= UNIT_X;
                rel_en_reg[i]  <= 1'b0;
                rel_val_reg[i] <= 32'h0;
            end
        end else begin
            cfg_err_reg <= 1'b0;
            if (CFG_WE) begin
                case (CFG_SEL)
                    SEL_DIGITS: begin
                        if (cfg_batt) begin
                            cfg_err_reg <= 1'b1;
                        end else if (CFG_DATA[31:3] == 29'h0 && (CFG_DATA[2:0] == DIGITS_4 ||
                                     CFG_DATA[2:0] == DIGITS_5 || CFG_DATA[2:0] == DIGITS_6)) begin
                            digits_reg[CFG_FUNC] <= CFG_DATA[2:0];
                        end else begin
                            cfg_err_reg <= 1'b1;
                        end
                    end
                    SEL_AVG_EN:  avg_en_reg[CFG_FUNC]  <= CFG_DATA[0];
                    SEL_COUNT: begin
                        if (CFG_DATA[31:CNT_W] == '0 && CFG_DATA[CNT_W-1:0] >= CNT_MIN &&
                            CFG_DATA[CNT_W-1:0] <= CNT_MAX) begin
                            count_reg[CFG_FUNC] <= CFG_DATA[CNT_W-1:0];
                        end else begin
                            cfg_err_reg <= 1'b1;
                        end
                    end
                    SEL_WINDOW: begin
                        if (CFG_DATA[31:3] == 29'h0 && CFG_DATA[2:0] <= WIN_100) begin
                            window_reg[CFG_FUNC] <= CFG_DATA[2:0];
                        end else begin
                            cfg_err_reg <= 1'b1;
                        end
                    end
                    SEL_FTYPE:   cfg_err_reg <= (CFG_DATA != FTYPE_MOVING);
                    SEL_MATH_EN: math_en_reg[CFG_FUNC] <= CFG_DATA[0];
                    SEL_GAIN:    gain_reg[CFG_FUNC]    <= CFG_DATA;
                    SEL_MOFFSET: moff_reg[CFG_FUNC]    <= CFG_DATA;
                    SEL_UNIT: begin
                        if ((CFG_DATA[7:0] >= 8'h41 && CFG_DATA[7:0] <= 8'h5a) ||
                            (CFG_DATA[7:0] >= 8'h61 && CFG_DATA[7:0] <= 8'h7a)) begin
                            unit_reg[CFG_FUNC] <= CFG_DATA[7:0];
                        end else begin
                            cfg_err_reg <= 1'b1;
                        end
                    end
                    SEL_REL_EN:  rel_en_reg[CFG_FUNC]  <= CFG_DATA[0];
                    SEL_REL_VAL: rel_val_reg[CFG_FUNC] <= CFG_DATA;
                    default:     cfg_err_reg <= 1'b1;
                endcase
            end
        end
    end

    // averaging history
    logic [DATA_W-1:0]  hist_reg [0:DEPTH-1];
    logic [CNT_W-1:0]   ptr_reg;
    logic [CNT_W-1:0]   hist_cnt_reg;
    logic [DATA_W+7:0]  sum_reg;
    logic [DATA_W-1:0]  avg_reg;
    rasp_flt_t          flt_state_reg;
    logic [1:0]         func_seen_reg;
    logic               use_avg;
    logic               refill;
    logic               step;
    logic [CNT_W-1:0]   cnt_now;
    logic [DATA_W:0]    diff;
    logic [DATA_W:0]    mag;
    logic [DATA_W-1:0]  limit;
    logic [DATA_W+7:0]  sum_next;
    logic [DATA_W+7:0]  avg_wide;
    logic [DATA_W-1:0]  filt_next;

    assign cnt_now = count_reg[FUNC_SEL];
    assign use_avg = supply && avg_en_reg[FUNC_SEL] && curr_path;

    always_comb begin
        diff = {IN_DATA[DATA_W-1], IN_DATA} - {avg_reg[DATA_W-1], avg_reg};
        mag  = diff[DATA_W] ? -diff : diff;
        case (window_reg[FUNC_SEL])
            WIN_0P01: limit = IN_RANGE_FS / WIN_DIV_0P01;
            WIN_0P1:  limit = IN_RANGE_FS / WIN_DIV_0P1;
            WIN_1:    limit = IN_RANGE_FS / WIN_DIV_1;
            WIN_10:   limit = IN_RANGE_FS / WIN_DIV_10;
            default:  limit = IN_RANGE_FS;
        endcase
        step = (window_reg[FUNC_SEL] != WIN_100) && (mag > {1'b0, limit});
        refill = (flt_state_reg == FLT_EMPTY) || step || (hist_cnt_reg != cnt_now);
        if (refill) begin
            sum_next = 40'($signed(IN_DATA) * $signed({1'b0, cnt_now}));
        end else begin
            sum_next = sum_reg - 40'($signed(hist_reg[ptr_reg])) + 40'($signed(IN_DATA));
        end
        avg_wide  = 40'($signed(sum_next) / $signed({33'h0, cnt_now}));
        filt_next = refill ? IN_DATA : avg_wide[DATA_W-1:0];
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            flt_state_reg <= FLT_EMPTY;
            ptr_reg       <= '0;
            hist_cnt_reg  <= CNT_RESET;
            sum_reg       <= '0;
            avg_reg       <= '0;
            func_seen_reg <= FUNC_VOLT;
            for (int i = 0; i < DEPTH; i++) begin
                hist_reg[i] <= '0;
            end
        end else begin
            func_seen_reg <= FUNC_SEL;
            if (FILT_CLR || !supply || !avg_en_reg[FUNC_SEL] || func_seen_reg != FUNC_SEL) begin
                flt_state_reg <= FLT_EMPTY;
            end else if (IN_VALID && use_avg) begin
                flt_state_reg <= FLT_RUN;
                sum_reg       <= sum_next;
                avg_reg       <= filt_next;
                hist_cnt_reg  <= cnt_now;
                if (refill) begin
                    for (int i = 0; i < DEPTH; i++) begin
                        hist_reg[i] <= IN_DATA;
                    end
                    ptr_reg <= (cnt_now > 7'h1) ? 7'h1 : 7'h0;
                end else begin
                    hist_reg[ptr_reg] <= IN_DATA;
                    ptr_reg <= (ptr_reg == cnt_now - 7'h1) ? 7'h0 : ptr_reg + 7'h1;
                end
            end
        end
    end

    // stage 1: filter result with its context
    logic              s1_valid_reg;
    logic [DATA_W-1:0] s1_data_reg;
    logic              s1_proc_reg;
    logic [1:0]        s1_func_reg;
    logic [2:0]        s1_digits_reg;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s1_valid_reg  <= 1'b0;
            s1_data_reg   <= '0;
            s1_proc_reg   <= 1'b0;
            s1_func_reg   <= FUNC_VOLT;
            s1_digits_reg <= DIGITS_6;
        end else begin
            s1_valid_reg <= IN_VALID;
            if (IN_VALID) begin
                s1_data_reg   <= use_avg ? filt_next : IN_DATA;
                s1_proc_reg   <= supply && curr_path;
                s1_func_reg   <= FUNC_SEL;
                // digits captured with the reading so later changes wait for the next one
                s1_digits_reg <= supply ? digits_reg[FUNC_SEL] : DIGITS_6;
            end
        end
    end

    // stage 2: relative offset, then m*x+b
    logic [DATA_W-1:0] rel_x;
    logic [63:0]       prod;
    logic [DATA_W-1:0] mxb;
    logic              do_math;

    always_comb begin
        rel_x = (s1_proc_reg && rel_en_reg[s1_func_reg]) ?
                s1_data_reg - rel_val_reg[s1_func_reg] : s1_data_reg;
        prod  = $signed(gain_reg[s1_func_reg]) * $signed(rel_x);
        mxb   = 32'(prod >>> GAIN_FRAC) + moff_reg[s1_func_reg];
        do_math = s1_proc_reg && math_en_reg[s1_func_reg];
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            OUT_VALID  <= 1'b0;
            OUT_DATA   <= '0;
            BUF_DATA   <= '0;
            OUT_DIGITS <= DIGITS_6;
        end else begin
            OUT_VALID <= s1_valid_reg;
            if (s1_valid_reg) begin
                OUT_DATA   <= do_math ? mxb : rel_x;
                BUF_DATA   <= (BUF_SRC_POST && do_math) ? mxb : rel_x;
                OUT_DIGITS <= s1_digits_reg;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            REF_CONV_EN               <= 1'b0;
            POSTPROC_ACTIVE_INDICATOR <= 1'b0;
            OUT_UNIT                  <= UNIT_X;
            CFG_ERR                   <= 1'b0;
        end else begin
            REF_CONV_EN <= AUTOZERO_EN;
            POSTPROC_ACTIVE_INDICATOR <= supply &&
                (avg_en_reg[FUNC_SEL] || math_en_reg[FUNC_SEL]);
            OUT_UNIT <= (supply && math_en_reg[FUNC_SEL]) ? unit_reg[FUNC_SEL] : UNIT_X;
            CFG_ERR  <= cfg_err_reg;
        end
    end

    ref_follow_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $changed(AUTOZERO_EN) |=> REF_CONV_EN == $past(AUTOZERO_EN))
        else $error("reference enable does not follow autozero");

    batt_digits_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        IN_VALID && OP_MODE != MODE_SUPPLY |-> ##2 OUT_DIGITS == DIGITS_6)
        else $error("battery mode reading not at highest digits");

    digits_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        CFG_WE && CFG_SEL == SEL_DIGITS && OP_MODE != MODE_SUPPLY |=>
        digits_reg[$past(CFG_FUNC)] == $past(digits_reg[CFG_FUNC]) ##1 CFG_ERR)
        else $error("digits changed in battery mode");

    batt_bypass_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        IN_VALID && OP_MODE != MODE_SUPPLY |-> ##2 OUT_VALID && OUT_DATA == $past(IN_DATA, 2))
        else $error("battery mode reading was processed");

    volt_pass_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        IN_VALID && FUNC_SEL == FUNC_CONC && !IN_IS_CURRENT |->
        ##2 OUT_DATA == $past(IN_DATA, 2))
        else $error("concurrent voltage reading was altered");

    first_fill_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        IN_VALID && use_avg && flt_state_reg == FLT_EMPTY && !FILT_CLR &&
        func_seen_reg == FUNC_SEL |=> avg_reg == $past(IN_DATA) && flt_state_reg == FLT_RUN)
        else $error("first reading not passed straight through");

    clear_empty_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        FILT_CLR |=> flt_state_reg == FLT_EMPTY)
        else $error("clear did not empty history");

    count_range_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        flt_state_reg == FLT_RUN |-> hist_cnt_reg >= CNT_MIN && hist_cnt_reg <= CNT_MAX)
        else $error("history count out of range");

    indicator_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $rose(POSTPROC_ACTIVE_INDICATOR) |->
        $past(avg_en_reg[FUNC_SEL] || math_en_reg[FUNC_SEL]))
        else $error("indicator raised without averaging or scaling");

    latency_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        IN_VALID |-> ##1 s1_valid_reg ##1 OUT_VALID)
        else $error("result not produced two cycles after reading");
endmodule : rasp_pipeline
`default_nettype wire

/* File: shared/rasp_pkg.sv */
// package for the reading average / scale pipeline
// assumes one clock domain; used by hw/rasp_pipeline.sv and by the test front end and bench
`default_nettype none
package rasp_pkg;
    localparam int DATA_W       = 32;
    localparam int CNT_W        = 7;
    localparam int HIST_DEPTH   = 100;
    localparam logic [CNT_W-1:0] CNT_MIN     = 7'h02;
    localparam logic [CNT_W-1:0] CNT_MAX     = 7'h64;
    localparam logic [CNT_W-1:0] CNT_RESET   = 7'h0a;
    // display digit codes
    localparam logic [2:0] DIGITS_4 = 3'h4;
    localparam logic [2:0] DIGITS_5 = 3'h5;
    localparam logic [2:0] DIGITS_6 = 3'h6;
    // operating modes
    localparam logic [1:0] MODE_SUPPLY   = 2'h0;
    localparam logic [1:0] MODE_BATTTEST = 2'h1;
    localparam logic [1:0] MODE_BATTEMU  = 2'h2;
    // measurement functions
    localparam logic [1:0] FUNC_VOLT = 2'h0;
    localparam logic [1:0] FUNC_CURR = 2'h1;
    localparam logic [1:0] FUNC_CONC = 2'h2;
    // filter type: only moving average is accepted
    localparam logic [31:0] FTYPE_MOVING = 32'h0000_0000;
    // window codes: 0.01, 0.1, 1, 10, 100 percent of range
    localparam logic [2:0] WIN_0P01 = 3'h0;
    localparam logic [2:0] WIN_0P1  = 3'h1;
    localparam logic [2:0] WIN_1    = 3'h2;
    localparam logic [2:0] WIN_10   = 3'h3;
    localparam logic [2:0] WIN_100  = 3'h4;
    localparam logic [31:0] WIN_DIV_0P01 = 32'h0000_2710;
    localparam logic [31:0] WIN_DIV_0P1  = 32'h0000_03e8;
    localparam logic [31:0] WIN_DIV_1    = 32'h0000_0064;
    localparam logic [31:0] WIN_DIV_10   = 32'h0000_000a;
    // configuration selectors
    localparam logic [3:0] SEL_DIGITS  = 4'h0;
    localparam logic [3:0] SEL_AVG_EN  = 4'h1;
    localparam logic [3:0] SEL_COUNT   = 4'h2;
    localparam logic [3:0] SEL_WINDOW  = 4'h3;
    localparam logic [3:0] SEL_FTYPE   = 4'h4;
    localparam logic [3:0] SEL_MATH_EN = 4'h5;
    localparam logic [3:0] SEL_GAIN    = 4'h6;
    localparam logic [3:0] SEL_MOFFSET = 4'h7;
    localparam logic [3:0] SEL_UNIT    = 4'h8;
    localparam logic [3:0] SEL_REL_EN  = 4'h9;
    localparam logic [3:0] SEL_REL_VAL = 4'ha;
    // gain is signed Q16.16
    localparam int GAIN_FRAC = 16;
    localparam logic [31:0] GAIN_ONE   = 32'h0001_0000;
    localparam logic [7:0]  UNIT_X     = 8'h78;
    typedef enum logic {FLT_EMPTY = 1'b0, FLT_RUN = 1'b1} rasp_flt_t;
endpackage : rasp_pkg
`default_nettype wire

/* File: test/rasp_front_end.sv */
// front-end model: issues queued readings as one-cycle pulses
// assumes the bench queues readings with send and polls pending
`default_nettype none
module rasp_front_end
    import rasp_pkg::*;
(
    input  wire logic         CLOCK,
    input  wire logic         RST_B,
    input  wire logic         SLOW,
    output logic              IN_VALID,
    output logic [DATA_W-1:0] IN_DATA,
    output logic              IN_IS_CURRENT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W:0] pend_q[$];
    logic            gap_reg;
    task automatic send(input logic [DATA_W-1:0] d, input logic cur);
        pend_q.push_back({cur, d});
    endtask : send
    function automatic int pending();
        return pend_q.size();
    endfunction : pending
    // idle lines toggle every cycle so a stale reading is never trusted
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            IN_VALID      <= 1'b0;
            IN_DATA       <= '0;
            IN_IS_CURRENT <= 1'b0;
            gap_reg       <= 1'b0;
        end else if (pend_q.size() != 0 && (!SLOW || gap_reg)) begin
            {IN_IS_CURRENT, IN_DATA} <= pend_q.pop_front();
            IN_VALID      <= 1'b1;
            gap_reg       <= 1'b0;
        end else begin
            IN_VALID      <= 1'b0;
            IN_DATA       <= ~IN_DATA;
            IN_IS_CURRENT <= ~IN_IS_CURRENT;
            gap_reg       <= 1'b1;
        end
    end
endmodule : rasp_front_end
`default_nettype wire

/* File: test/rasp_pipeline_bench.sv */
// bench: integer model of the pipeline compared at every result
// assumes rasp_pkg and rasp_front_end are compiled first
`default_nettype none
module rasp_pipeline_bench
    import rasp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rst_b, autozero_en, in_valid, in_is_current, filt_clr, buf_src_post;
    logic        cfg_we, slow, cfg_err, ref_conv_en, out_valid, post_ind;
    logic [1:0]  op_mode, func_sel, cfg_func;
    logic [3:0]  cfg_sel;
    logic [2:0]  out_digits;
    logic [7:0]  out_unit;
    logic [31:0] in_data, in_range_fs, cfg_data, out_data, buf_data;
    int          fail_count, total_checks, seed, last_avg, prev_func;
    int          dig[3], avg[3], cnt[3], win[3], mth[3], gain[3], moff[3], unit[3], rel[3], relv[3];
    int          ov[3], od[3], bd[3], dg[3], ce[3], az[2], hist[$];
    int          sp[5] = '{3, 30, 300, 3000, 30000};
    int          cnts[5] = '{1, 2, 101, 4, 100};
    longint      divs[4] = '{WIN_DIV_0P01, WIN_DIV_0P1, WIN_DIV_1, WIN_DIV_10};
    bit          empty;
    rasp_pipeline i_rasp_pipeline (.CLOCK(clock), .RST_B(rst_b), .OP_MODE(op_mode),
        .FUNC_SEL(func_sel), .AUTOZERO_EN(autozero_en), .IN_VALID(in_valid), .IN_DATA(in_data),
        .IN_IS_CURRENT(in_is_current), .IN_RANGE_FS(in_range_fs), .FILT_CLR(filt_clr),
        .BUF_SRC_POST(buf_src_post), .CFG_WE(cfg_we), .CFG_FUNC(cfg_func), .CFG_SEL(cfg_sel),
        .CFG_DATA(cfg_data), .CFG_ERR(cfg_err), .REF_CONV_EN(ref_conv_en), .OUT_VALID(out_valid),
        .OUT_DATA(out_data), .BUF_DATA(buf_data), .OUT_DIGITS(out_digits), .OUT_UNIT(out_unit),
        .POSTPROC_ACTIVE_INDICATOR(post_ind));
    rasp_front_end i_rasp_front_end (.CLOCK(clock), .RST_B(rst_b), .SLOW(slow),
        .IN_VALID(in_valid), .IN_DATA(in_data), .IN_IS_CURRENT(in_is_current));
    task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : cmp_word
    task automatic cmp_bit(string n, logic e, logic g);
        cmp_word(n, {31'h0, e}, {31'h0, g});
    endtask : cmp_bit
    function automatic void take(int x, bit cur);
        int     a = x;
        int     f = func_sel;
        longint d = longint'(x) - last_avg;
        od[0] = x;
        bd[0] = x;
        dg[0] = DIGITS_6;
        if (op_mode != MODE_SUPPLY) return;
        dg[0] = dig[f];
        if (f == FUNC_CONC && !cur) return;
        if (d < 0) d = -d;
        if (avg[f] != 0) begin
            if (empty || hist.size() != cnt[f] || (win[f] < 4 && d > in_range_fs / divs[win[f]])) begin
                hist.delete();
                repeat (cnt[f]) hist.push_back(x);
            end else begin
                hist.push_front(x);
                void'(hist.pop_back());
                a = hist.sum() / cnt[f];
            end
            last_avg = a;
            empty = 0;
        end
        if (rel[f] != 0) a = a - relv[f];
        bd[0] = a;
        if (mth[f] != 0) a = int'((longint'(gain[f]) * a) >>> GAIN_FRAC) + moff[f];
        od[0] = a;
        if (buf_src_post) bd[0] = a;
    endfunction : take
    function automatic int apply(int f, int s, int d);
        case (s)
            0: if (d >= 4 && d <= 6 && op_mode == MODE_SUPPLY) dig[f] = d; else return 1;
            1: avg[f] = d & 1;
            2: if (d >= 2 && d <= 100) cnt[f] = d; else return 1;
            3: if (d >= 0 && d <= 4) win[f] = d; else return 1;
            4: if (d != 0) return 1;
            5: mth[f] = d & 1;
            6: gain[f] = d;
            7: moff[f] = d;
            8: if ((d >= 32'h41 && d <= 32'h5a) || (d >= 32'h61 && d <= 32'h7a)) unit[f] = d; else return 1;
            9: rel[f] = d & 1;
            10: relv[f] = d;
            default: return 1;
        endcase
        return 0;
    endfunction : apply
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dig = '{3{DIGITS_6}}; avg = '{3{0}}; cnt = '{3{CNT_RESET}}; win = '{3{0}};
            mth = '{3{0}}; gain = '{3{GAIN_ONE}}; moff = '{3{0}}; unit = '{3{UNIT_X}};
            rel = '{3{0}}; relv = '{3{0}}; ov = '{3{0}}; ce = '{3{0}}; az = '{2{0}};
            hist.delete(); empty = 1; prev_func = 0; last_avg = 0;
        end else begin
            // results of the reading taken two edges ago are due now
            for (int i = 2; i > 0; i--) begin
                {ov[i], od[i], bd[i], dg[i], ce[i]} = {ov[i-1], od[i-1], bd[i-1], dg[i-1], ce[i-1]};
            end
            cmp_bit("out_valid", ov[2][0], out_valid);
            if (ov[2] != 0) begin
                cmp_word("out_data", od[2], out_data);
                cmp_word("buf_data", bd[2], buf_data);
                cmp_word("out_digits", dg[2], {29'h0, out_digits});
            end
            cmp_bit("cfg_err", ce[2][0], cfg_err);
            cmp_bit("ref_conv_en", az[0][0], ref_conv_en);
            az[0] = autozero_en;
            if (op_mode != MODE_SUPPLY || filt_clr || avg[func_sel] == 0 || func_sel != prev_func)
                empty = 1;
            prev_func = func_sel;
            ov[0] = in_valid;
            if (in_valid) take(in_data, in_is_current);
            ce[0] = cfg_we ? apply(cfg_func, cfg_sel, cfg_data) : 0;
        end
    end
    task automatic cfg(int f, int s, int d);
        cfg_we   <= 1'b1;
        cfg_func <= f[1:0];
        cfg_sel  <= s[3:0];
        cfg_data <= d;
        @(posedge clock);
        cfg_we   <= 1'b0;
        @(posedge clock);
    endtask : cfg
    // cur below zero picks a random voltage or current tag per reading
    task automatic burst(int n, int span, int cur);
        int k = 0;
        slow        <= $random(seed);
        autozero_en <= $random(seed);
        repeat (n) i_rasp_front_end.send($random(seed) % span, cur < 0 ? $random(seed) : cur);
        while (i_rasp_front_end.pending() != 0 && k < 1000) begin
            @(posedge clock);
            k++;
        end
        if (k >= 1000) fail_count++;
        repeat (4) @(posedge clock);
        cmp_word("out_unit", (op_mode == MODE_SUPPLY && mth[func_sel] != 0) ? unit[func_sel]
                 : UNIT_X, {24'h0, out_unit});
        cmp_bit("indicator", op_mode == MODE_SUPPLY && (avg[func_sel] | mth[func_sel]) != 0,
                post_ind);
    endtask : burst
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        #2000000;
        fail_count++;
        give_verdict();
    end
    initial begin
        {seed, fail_count, total_checks} = {32'd91, 64'h0};
        {rst_b, autozero_en, filt_clr, buf_src_post, cfg_we, slow} = '0;
        {op_mode, func_sel, cfg_func, cfg_sel, cfg_data} = '0;
        in_range_fs = 32'h0000_2710;
        repeat (5) @(posedge clock);
        cmp_word("reset digits", DIGITS_6, {29'h0, out_digits});
        cmp_word("reset unit", UNIT_X, {24'h0, out_unit});
        rst_b <= 1'b1;
        @(posedge clock);
        for (int f = 0; f < 3; f++) begin
            func_sel <= f[1:0];
            for (int c = 7; c >= 3; c--) begin
                cfg(f, SEL_DIGITS, c);
                burst(1, 500, 1);
            end
        end
        $display("test digits done");
        func_sel <= FUNC_CURR;
        cfg(1, SEL_AVG_EN, 1);
        cfg(1, SEL_WINDOW, 4);
        foreach (cnts[i]) begin
            cfg(1, SEL_COUNT, cnts[i]);
            burst(cnts[i] + 6, 1000, 1);
        end
        filt_clr <= 1'b1;
        @(posedge clock);
        filt_clr <= 1'b0;
        burst(5, 1000, 1);
        cfg(1, SEL_FTYPE, 1);
        cfg(1, SEL_FTYPE, 0);
        for (int s = 11; s < 16; s++) cfg(1, s, 0);
        $display("test averaging done");
        cfg(1, SEL_COUNT, 4);
        for (int w = 5; w >= 0; w--) begin
            in_range_fs <= 32'h0000_2710 + ($random(seed) & 32'h0000_3fff);
            cfg(1, SEL_WINDOW, w);
            burst(12, sp[w % 5], 1);
        end
        $display("test window done");
        cfg(1, SEL_REL_VAL, 5);
        cfg(1, SEL_REL_EN, 1);
        cfg(1, SEL_GAIN, 32'h0001_8000);
        cfg(1, SEL_MOFFSET, -3);
        cfg(1, SEL_UNIT, 32'h31);
        cfg(1, SEL_UNIT, 32'h41);
        cfg(1, SEL_MATH_EN, 1);
        for (int b = 0; b < 2; b++) begin
            buf_src_post <= b[0];
            burst(8, 1000, 1);
        end
        func_sel <= FUNC_VOLT;
        burst(4, 1000, 0);
        cfg(0, SEL_GAIN, 32'hfffe_0000);
        cfg(0, SEL_MATH_EN, 1);
        burst(4, 1000, 0);
        cfg(2, SEL_AVG_EN, 1);
        cfg(2, SEL_MATH_EN, 1);
        cfg(2, SEL_REL_EN, 1);
        cfg(2, SEL_REL_VAL, 7);
        func_sel <= FUNC_CONC;
        burst(20, 1000, -1);
        $display("test math done");
        for (int m = 1; m < 3; m++) begin
            op_mode <= m[1:0];
            cfg(2, SEL_DIGITS, 4);
            burst(6, 1000, -1);
        end
        op_mode <= MODE_SUPPLY;
        burst(4, 1000, 1);
        $display("test battery done");
        give_verdict();
    end
endmodule : rasp_pipeline_bench
`default_nettype wire
